/* pkg/fru_pkg.sv */
`default_nettype none
package fru_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SEC_CYCLES = 1_000_000_000 / CLK_PERIOD_NS;
  // retry waits and limits in seconds
  localparam logic [13:0] WAIT1_S = 14'd1;
  localparam logic [13:0] WAIT2_S = 14'd5;
  localparam logic [13:0] WAIT3_S = 14'd10;
  localparam logic [13:0] WAITN_S = 14'd60;
  localparam logic [13:0] LIM5M_S = 14'd300;
  localparam logic [13:0] LIM10M_S = 14'd600;
  localparam logic [13:0] LIM30M_S = 14'd1800;
  localparam logic [13:0] LIM1H_S = 14'd3600;
  localparam logic [13:0] LIM2H_S = 14'd7200;
  localparam logic [13:0] LIM3H_S = 14'd10800;
  localparam logic [13:0] CONFIRM_HOLD_S = 14'd2;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CLRSEL = 8'h04;
  localparam logic [7:0] OFS_REINIT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQSTAT = 8'h10;
  localparam logic [7:0] OFS_IRQMASK = 8'h14;
  // CTRL fields
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_LIM_LSB = 1;
  localparam int CTRL_IOPROF_BIT = 4;
  localparam int CTRL_EXPERT_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // CLRSEL fields: kind in [2:0], index in [6:3]
  localparam int CLRSEL_IDX_LSB = 3;
  localparam logic [6:0] CLRSEL_RESET = 7'h00;
  localparam logic [4:0] IRQ_RESET = 5'h00;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_RECOVER = 1;
  localparam int IRQ_ABANDON = 2;
  localparam int IRQ_MCLEAR = 3;
  localparam int IRQ_REINIT = 4;

  typedef enum logic [2:0] {
    LIM_5M = 3'b000, LIM_10M = 3'b001, LIM_30M = 3'b010, LIM_1H = 3'b011,
    LIM_2H = 3'b100, LIM_3H = 3'b101, LIM_UNL = 3'b110
  } fru_limit_t;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000, SRC_BASE = 3'b001, SRC_EXT = 3'b010, SRC_BASE_LOW = 3'b011,
    SRC_CAB = 3'b100, SRC_CMD = 3'b101
  } fru_src_sel_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000, ST_RETRY = 3'b001, ST_LOCK = 3'b010, ST_ABANDON = 3'b011,
    ST_REINIT_CLR = 3'b100, ST_REINIT_RST = 3'b101
  } fru_state_t;

  typedef struct packed {
    logic [5:0] diBase;
    logic [5:0] diExt;
    logic [7:0] diCab;
    logic [15:0] cmdWord;
  } fru_inputs_t;

  typedef struct packed {
    logic stopReset;
    logic confirm;
  } fru_keys_t;
endpackage : fru_pkg
`default_nettype wire

/* design/fru_tick.sv */
`timescale 1ns/10ps
`default_nettype none
module fru_tick #(
  parameter int unsigned CYCLES = fru_pkg::SEC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic restart,
  output logic tick
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_r;

  // restart realigns the second boundary to the event
  always_ff @(posedge clk_sys)
  begin
    if (reset || restart)
    begin
      cnt_r <= '0;
      tick <= 1'b0;
    end
    else if (cnt_r == W'(CYCLES - 1))
    begin
      cnt_r <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule : fru_tick
`default_nettype wire

/* design/fru_controller.sv */
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Function
// - auto recovery is off after reset; when on, the locked fault restarts only once the error is gone and run is permitted.
// - retry attempts are spaced by waits of 1 s, 5 s, 10 s and then 60 s for every later attempt.
// - when the recovery time limit runs out without success, auto recovery stops and the lock holds until power cycle.
// - the time limit selects 5, 10 or 30 min, 1, 2 or 3 h or unlimited, with 5 min after reset.
// - the time limit acts only while auto recovery is enabled, bounding repeated restarts.
// - the fault relay stays energised while auto recovery is in progress.
// - the fault-state output is low during retries and goes high once the device stays in fault.
// - a rising edge of the selected manual-clear source clears errors whose cause has gone, except once the time limit has run out.
// - the keypad stop/reset key clears errors just like the manual-clear source.
// - the manual-clear selector resets to none and offers base, extension, base low-level and cabinet inputs.
// - command word bits 0 to 10 serve as sources only in the I/O profile, bits 11 to 15 always.
// - reinitialisation first clears all errors, then restarts as after power off and on.
// - holding confirm for 2 s triggers reinitialisation and the request bit self-clears when done.
// - reinitialisation is accepted only when locked in fault and with expert access.
module fru_controller #(
  parameter int unsigned SEC_CYCLES = fru_pkg::SEC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic faultCause,
  input wire logic runPermit,
  input wire fru_pkg::fru_inputs_t srcIn,
  input wire fru_pkg::fru_keys_t keys,
  output logic faultRelay,
  output logic faultStateOut,
  output logic errClear,
  output logic drvRestart,
  output logic irq
);
  import fru_pkg::*;

  fru_state_t state_r, state_nxt;
  logic [5:0] ctrl_r;
  logic [6:0] clrSel_r;
  logic reinitReq_r;
  logic [4:0] irqStat_r, irqMask_r, irqEvt;
  logic [13:0] waitSec_r, totalSec_r, holdSec_r;
  logic [7:0] attempt_r;
  logic clrSrc_r, keyStop_r, confirmDone_r;
  logic secTick, tickRestart;
  logic autoEn, expert, ioProfile;
  fru_limit_t limSel;
  logic clrLevel, manualClr, locked, waitDone, limitHit, reinitGo;
  logic apbWr, apbRd, addrOk;

  assign autoEn = ctrl_r[CTRL_AUTO_BIT];
  assign limSel = fru_limit_t'(ctrl_r[CTRL_LIM_LSB +: 3]);
  assign ioProfile = ctrl_r[CTRL_IOPROF_BIT];
  assign expert = ctrl_r[CTRL_EXPERT_BIT];

  // wait in seconds for the current attempt number
  function automatic logic [13:0] retryWait(input logic [7:0] n);
    unique case (n)
      8'h00: retryWait = WAIT1_S;
      8'h01: retryWait = WAIT2_S;
      8'h02: retryWait = WAIT3_S;
      default: retryWait = WAITN_S;
    endcase
  endfunction : retryWait

  function automatic logic [13:0] limitSec(input fru_limit_t s);
    unique case (s)
      LIM_5M: limitSec = LIM5M_S;
      LIM_10M: limitSec = LIM10M_S;
      LIM_30M: limitSec = LIM30M_S;
      LIM_1H: limitSec = LIM1H_S;
      LIM_2H: limitSec = LIM2H_S;
      LIM_3H: limitSec = LIM3H_S;
      default: limitSec = '1;
    endcase
  endfunction : limitSec

  // a base or extension index above 5 or an unsupported kind reads as not assigned
  function automatic logic srcLevel(input logic [6:0] sel, input fru_inputs_t in, input logic iop);
    logic [3:0] idx;
    idx = sel[CLRSEL_IDX_LSB +: 4];
    srcLevel = 1'b0;
    unique case (fru_src_sel_t'(sel[2:0]))
      SRC_BASE: srcLevel = (idx < 4'd6) ? in.diBase[idx[2:0]] : 1'b0;
      SRC_EXT: srcLevel = (idx < 4'd6) ? in.diExt[idx[2:0]] : 1'b0;
      SRC_BASE_LOW: srcLevel = (idx < 4'd6) ? ~in.diBase[idx[2:0]] : 1'b0;
      SRC_CAB: srcLevel = in.diCab[idx[2:0]];
      SRC_CMD: srcLevel = (idx > 4'd10 || iop) ? in.cmdWord[idx] : 1'b0;
      default: srcLevel = 1'b0;
    endcase
  endfunction : srcLevel

  fru_tick #(
    .CYCLES(SEC_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .reset(reset),
    .restart(tickRestart),
    .tick(secTick)
  );

  // timers realign on entry to the fault state
  assign tickRestart = (state_r == ST_RUN) && faultCause;

  assign clrLevel = srcLevel(clrSel_r, srcIn, ioProfile);
  assign manualClr = (clrLevel && !clrSrc_r) || (keys.stopReset && !keyStop_r);
  assign locked = (state_r == ST_RETRY) || (state_r == ST_LOCK) || (state_r == ST_ABANDON);
  assign waitDone = secTick && (waitSec_r + 14'd1 >= retryWait(attempt_r));
  assign limitHit = secTick && (limSel != LIM_UNL) && (totalSec_r + 14'd1 >= limitSec(limSel));
  assign reinitGo = reinitReq_r && locked && expert;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      clrSrc_r <= 1'b0;
      keyStop_r <= 1'b0;
    end
    else
    begin
      clrSrc_r <= clrLevel;
      keyStop_r <= keys.stopReset;
    end
  end

  // state machine
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN:
        if (faultCause)
          state_nxt = autoEn ? ST_RETRY : ST_LOCK;
      ST_RETRY:
        if (reinitGo)
          state_nxt = ST_REINIT_CLR;
        else if (manualClr && !faultCause)
          state_nxt = ST_RUN;
        else if (!autoEn)
          state_nxt = ST_LOCK;
        else if (limitHit)
          state_nxt = ST_ABANDON;
        else if (waitDone && !faultCause && runPermit)
          state_nxt = ST_RUN;
      ST_LOCK:
        if (reinitGo)
          state_nxt = ST_REINIT_CLR;
        else if (manualClr && !faultCause)
          state_nxt = ST_RUN;
      ST_ABANDON:
        // only a reinitialisation stands in for the power cycle here
        if (reinitGo)
          state_nxt = ST_REINIT_CLR;
      ST_REINIT_CLR:
        state_nxt = ST_REINIT_RST;
      ST_REINIT_RST:
        state_nxt = ST_RUN;
      default:
        state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // attempt spacing and overall limit on the common tick
  always_ff @(posedge clk_sys)
  begin
    if (reset || state_r != ST_RETRY)
    begin
      waitSec_r <= '0;
      totalSec_r <= '0;
      attempt_r <= '0;
    end
    else if (secTick)
    begin
      if (totalSec_r != '1)
        totalSec_r <= totalSec_r + 14'd1;
      if (waitDone)
      begin
        waitSec_r <= '0;
        if (attempt_r != '1)
          attempt_r <= attempt_r + 8'd1;
      end
      else
        waitSec_r <= waitSec_r + 14'd1;
    end
  end

  // confirm key hold timer, runs while confirm is held until the hold time is reached
  always_ff @(posedge clk_sys)
  begin
    if (reset || !keys.confirm)
    begin
      holdSec_r <= '0;
      confirmDone_r <= 1'b0;
    end
    else if (secTick && !confirmDone_r)
    begin
      if (holdSec_r + 14'd1 >= CONFIRM_HOLD_S)
        confirmDone_r <= 1'b1;
      holdSec_r <= holdSec_r + 14'd1;
    end
  end

  // outputs, all registered
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      faultRelay <= 1'b0;
      faultStateOut <= 1'b0;
      errClear <= 1'b0;
      drvRestart <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      faultRelay <= (state_nxt == ST_RUN) || (state_nxt == ST_RETRY);
      faultStateOut <= (state_nxt == ST_LOCK) || (state_nxt == ST_ABANDON);
      errClear <= (state_nxt == ST_REINIT_CLR) || ((state_r != ST_RUN) && (state_nxt == ST_RUN)
        && (state_r != ST_REINIT_RST));
      drvRestart <= (state_nxt == ST_REINIT_RST);
      irq <= |(irqStat_r & irqMask_r);
    end
  end

  // APB slave, zero wait states
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && penable && !pwrite;
  assign addrOk = (paddr == OFS_CTRL) || (paddr == OFS_CLRSEL) || (paddr == OFS_REINIT)
    || (paddr == OFS_STATUS) || (paddr == OFS_IRQSTAT) || (paddr == OFS_IRQMASK);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctrl_r <= CTRL_RESET;
      clrSel_r <= CLRSEL_RESET;
      irqMask_r <= IRQ_RESET;
    end
    else if (apbWr)
    begin
      if (paddr == OFS_CTRL)
        ctrl_r <= pwdata[5:0];
      if (paddr == OFS_CLRSEL)
        clrSel_r <= pwdata[6:0];
      if (paddr == OFS_IRQMASK)
        irqMask_r <= pwdata[4:0];
    end
  end

  // software or held confirm raises the request; completion drops it
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      reinitReq_r <= 1'b0;
    else if (state_r == ST_REINIT_RST)
      reinitReq_r <= 1'b0;
    else if ((apbWr && paddr == OFS_REINIT && pwdata[0]) || (keys.confirm && secTick && !confirmDone_r
      && holdSec_r + 14'd1 >= CONFIRM_HOLD_S))
      reinitReq_r <= 1'b1;
    else if (!locked || !expert)
      reinitReq_r <= 1'b0;
  end

  assign irqEvt[IRQ_FAULT] = (state_r == ST_RUN) && (state_nxt != ST_RUN);
  assign irqEvt[IRQ_RECOVER] = (state_r == ST_RETRY) && (state_nxt == ST_RUN) && !manualClr;
  assign irqEvt[IRQ_ABANDON] = (state_r == ST_RETRY) && (state_nxt == ST_ABANDON);
  assign irqEvt[IRQ_MCLEAR] = locked && (state_nxt == ST_RUN) && manualClr;
  assign irqEvt[IRQ_REINIT] = (state_r == ST_REINIT_RST);

  // new events win over the read that clears
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      irqStat_r <= IRQ_RESET;
    else if (apbRd && paddr == OFS_IRQSTAT)
      irqStat_r <= irqEvt;
    else
      irqStat_r <= irqStat_r | irqEvt;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
      prdata <= '0;
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          OFS_CTRL: prdata <= {26'h0, ctrl_r};
          OFS_CLRSEL: prdata <= {25'h0, clrSel_r};
          OFS_REINIT: prdata <= {31'h0, reinitReq_r};
          OFS_STATUS: prdata <= {8'h0, attempt_r, 5'h0, faultCause, faultStateOut, faultRelay,
            5'h0, state_r};
          OFS_IRQSTAT: prdata <= {27'h0, irqStat_r};
          OFS_IRQMASK: prdata <= {27'h0, irqMask_r};
          default: prdata <= '0;
        endcase
      end
    end
  end
endmodule : fru_controller
`default_nettype wire

/* verif/fru_src_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fru_src_model (
  input wire fru_pkg::fru_src_sel_t kind,
  input wire logic [3:0] idx,
  input wire logic act,
  output var fru_pkg::fru_inputs_t srcIn
);
  import fru_pkg::*;
  logic [15:0] hot;
  assign hot = 16'(act) << idx;
  // steady levels only, never pulses; low-level base pins rest high
  always_comb
  begin
    srcIn = '0;
    case (kind)
      SRC_BASE: srcIn.diBase = hot[5:0];
      SRC_EXT: srcIn.diExt = hot[5:0];
      SRC_BASE_LOW: srcIn.diBase = ~hot[5:0];
      SRC_CAB: srcIn.diCab = hot[7:0];
      SRC_CMD: srcIn.cmdWord = hot;
      default: srcIn.diCab = 8'h00;
    endcase
  end
endmodule : fru_src_model
`default_nettype wire

/* verif/fru_controller_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module fru_controller_asserts #(
  parameter int unsigned SEC_CYCLES = fru_pkg::SEC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic faultCause,
  input wire logic faultRelay,
  input wire logic faultStateOut,
  input wire logic errClear,
  input wire logic drvRestart
);
  import fru_pkg::*;
  logic autoEn_r;
  // shadow of the auto enable bit, taken from completed writes
  always_ff @(posedge clk_sys)
    if (reset)
      autoEn_r <= 1'h0;
    else if (psel && penable && pready && pwrite && paddr == OFS_CTRL)
      autoEn_r <= pwdata[CTRL_AUTO_BIT];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  property p_relay_excl;
    !(faultRelay && faultStateOut);
  endproperty
  a_relay_excl: assert property (p_relay_excl)
    else $error("relay and fault state both high");
  property p_lock_manual;
    faultRelay && faultCause && !autoEn_r |-> ##[1:2] (faultStateOut && !faultRelay);
  endproperty
  a_lock_manual: assert property (p_lock_manual)
    else $error("fault without auto did not lock");
  property p_retry_hold;
    $rose(faultCause) && faultRelay && autoEn_r |=> faultRelay && !faultStateOut;
  endproperty
  a_retry_hold: assert property (p_retry_hold)
    else $error("fault state shown during retry");
  property p_clear_pulse;
    errClear |=> !errClear;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse)
    else $error("clear pulse too long");
  property p_restart_order;
    drvRestart |-> $past(errClear) || $past(errClear, 2);
  endproperty
  a_restart_order: assert property (p_restart_order)
    else $error("restart without prior clear");
  property p_restart_run;
    drvRestart |-> ##[1:3] faultRelay;
  endproperty
  a_restart_run: assert property (p_restart_run)
    else $error("no run after restart");
  property p_apb_ready;
    psel && !penable |=> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("no ready in access cycle");
  property p_apb_err;
    pslverr |-> pready && (paddr > OFS_IRQMASK || paddr[1:0] != 2'h0);
  endproperty
  a_apb_err: assert property (p_apb_err)
    else $error("error on mapped address");
endmodule : fru_controller_asserts
bind fru_controller fru_controller_asserts #(.SEC_CYCLES(SEC_CYCLES)) u_chk (.clk_sys(clk_sys),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .faultCause(faultCause), .faultRelay(faultRelay),
  .faultStateOut(faultStateOut), .errClear(errClear), .drvRestart(drvRestart));
`default_nettype wire

/* verif/tb_fru_controller.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_fru_controller;
  import fru_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} fru_row_t;
  localparam int SC = 20;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, rde, act;
  logic faultCause, runPermit, faultRelay, faultStateOut, errClear, drvRestart, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdq;
  logic [3:0] mIdx;
  fru_src_sel_t mKind;
  fru_inputs_t srcIn;
  fru_keys_t keys;
  int n_errors, tests_run, n;
  fru_row_t rows [9] = '{'{1'h0, OFS_CTRL, 32'h0, 32'h0, 1'h0}, '{1'h0, OFS_CLRSEL, 32'h0, 32'h0, 1'h0},
    '{1'h0, OFS_STATUS, 32'h0, 32'h100, 1'h0}, '{1'h0, OFS_REINIT, 32'h0, 32'h0, 1'h0},
    '{1'h0, OFS_IRQMASK, 32'h0, 32'h0, 1'h0}, '{1'h1, 8'h18, 32'hffffffff, 32'h0, 1'h1},
    '{1'h0, 8'h18, 32'h0, 32'h0, 1'h1}, '{1'h1, OFS_CLRSEL, 32'hffffff8b, 32'h0, 1'h0},
    '{1'h0, OFS_CLRSEL, 32'h0, 32'h0b, 1'h0}};
  fru_src_sel_t sKind [7] = '{SRC_BASE, SRC_EXT, SRC_BASE_LOW, SRC_CAB, SRC_CMD, SRC_CMD, SRC_CMD};
  logic [3:0] sIdx [7] = '{4'h2, 4'h5, 4'h0, 4'h7, 4'hc, 4'h3, 4'h3};
  int rel [4] = '{10, 50, 200, 500};
  int wt [4] = '{1, 6, 16, 76};
  fru_controller #(.SEC_CYCLES(SC)) uut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .faultCause(faultCause), .runPermit(runPermit), .srcIn(srcIn), .keys(keys), .faultRelay(faultRelay),
    .faultStateOut(faultStateOut), .errClear(errClear), .drvRestart(drvRestart), .irq(irq));
  fru_src_model u_src (.kind(mKind), .idx(mIdx), .act(act), .srcIn(srcIn));
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s exp %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc
  task automatic waitHi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'h1 && n < lim)
    begin
      @(posedge clk_sys);
      n++;
    end
  endtask : waitHi
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do
      @(posedge clk_sys);
    while (pready !== 1'h1);
    rdq = prdata;
    rde = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask : apb
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  initial
  begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    n_errors++;
    wrap_up();
  end
  initial
  begin
    {reset, psel, penable, pwrite, faultCause, act} = 6'h20;
    paddr = 8'h00;
    pwdata = 32'h0;
    runPermit = 1'h1;
    keys = 2'h0;
    mKind = SRC_NONE;
    mIdx = 4'h0;
    cyc(6);
    reset <= 1'h0;
    cyc(1);
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk("rdata", rdq, rows[i].q);
      chk("slverr", 32'(rde), 32'(rows[i].e));
    end
    apb(1'h1, OFS_IRQMASK, 32'h1);
    faultCause <= 1'h1;
    cyc(4);
    chk("locked", 32'({faultRelay, faultStateOut, irq}), 32'h3);
    keys <= 2'h2;
    cyc(4);
    chk("clear with cause", 32'(faultStateOut), 32'h1);
    keys <= 2'h0;
    faultCause <= 1'h0;
    apb(1'h0, OFS_IRQSTAT, 32'h0);
    chk("irq status", rdq, 32'h1);
    keys <= 2'h2;
    waitHi(errClear, 10);
    cyc(2);
    chk("key clear", 32'({faultRelay, irq}), 32'h2);
    keys <= 2'h0;
    // row 5 is cmd bit 3 outside the I/O profile: must not clear; row 6 is the same bit inside it
    for (int i = 0; i < 7; i++)
    begin
      if (i == 6)
        apb(1'h1, OFS_CTRL, 32'h10);
      mKind <= sKind[i];
      mIdx <= sIdx[i];
      apb(1'h1, OFS_CLRSEL, {25'h0, sIdx[i], sKind[i]});
      faultCause <= 1'h1;
      cyc(3);
      faultCause <= 1'h0;
      act <= 1'h1;
      waitHi(errClear, 10);
      chk("source clear", 32'(n < 10), 32'(i != 5));
      act <= 1'h0;
      keys <= 2'h2;
      cyc(2);
      keys <= 2'h0;
      cyc(2);
    end
    apb(1'h1, OFS_CTRL, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      faultCause <= 1'h1;
      cyc(rel[i]);
      chk("retry outputs", 32'({faultRelay, faultStateOut}), 32'h2);
      faultCause <= 1'h0;
      waitHi(errClear, 2000);
      chk("retry wait", 32'(n + rel[i] >= wt[i] * SC && n + rel[i] <= wt[i] * SC + 4), 32'h1);
      cyc(3);
    end
    faultCause <= 1'h1;
    waitHi(faultStateOut, 7000);
    chk("limit", 32'(n >= 300 * SC && n <= 300 * SC + 4), 32'h1);
    faultCause <= 1'h0;
    keys <= 2'h2;
    cyc(1300);
    keys <= 2'h0;
    chk("abandoned", 32'({faultRelay, faultStateOut}), 32'h1);
    apb(1'h1, OFS_REINIT, 32'h1);
    cyc(2);
    apb(1'h0, OFS_REINIT, 32'h0);
    chk("reinit no expert", rdq, 32'h0);
    chk("still abandoned", 32'(faultStateOut), 32'h1);
    apb(1'h1, OFS_CTRL, 32'h21);
    keys <= 2'h1;
    waitHi(errClear, 3 * SC + 5);
    chk("confirm hold", 32'(n >= SC && n <= 2 * SC + 6), 32'h1);
    waitHi(drvRestart, 5);
    chk("restart", 32'(n < 5), 32'h1);
    keys <= 2'h0;
    cyc(3);
    chk("running", 32'({faultRelay, faultStateOut}), 32'h2);
    apb(1'h0, OFS_REINIT, 32'h0);
    chk("request cleared", rdq, 32'h0);
    keys <= 2'h1;
    waitHi(drvRestart, 3 * SC);
    chk("reinit in run", 32'(n), 32'(3 * SC));
    keys <= 2'h0;
    reset <= 1'h1;
    cyc(2);
    reset <= 1'h0;
    cyc(1);
    apb(1'h0, OFS_CTRL, 32'h0);
    chk("ctrl after reset", rdq, 32'h0);
    wrap_up();
  end
endmodule : tb_fru_controller
`default_nettype wire
